/* core/rpt_core.sv */
/*
 * Decode and execute slice for three nibble transfer instructions:
 * converter read, extension split and the three-cycle table read.
 * Assumes the surrounding CPU presents one instruction per cycle while
 * ready is high, drives pc in the cycle a table read is taken, and that program memory
 * answers a request with data on the following cycle.
 */
`timescale 1ns/10ps
module rpt_core (
   input  wire logic                          clk,
   input  wire logic                          rstn,
   input  wire logic                          instr_valid,
   input  wire rpt_pkg::rpt_word_t            instr,
   input  wire rpt_pkg::rpt_pc_t              pc,
   input  wire logic [rpt_pkg::AD_W-1:0]      ad_result,
   input  wire logic [rpt_pkg::BYTE_W-1:0]    cmp_reg,
   input  wire logic [rpt_pkg::NIB_W-1:0]     converter_ctrl_first,
   input  wire logic [rpt_pkg::BYTE_W-1:0]    ext_reg,
   input  wire rpt_pkg::rpt_word_t            rom_rdata,
   output logic                               ready,
   output logic                               hit,
   output rpt_pkg::rpt_regs_s                 regs,
   output logic [rpt_pkg::SP_W-1:0]           stack_pointer,
   output logic                               rom_req,
   output rpt_pkg::rpt_pc_t                   rom_addr,
   output logic                               pc_load,
   output rpt_pkg::rpt_pc_t                   pc_load_val,
   output logic                               carry_flag_we,
   output logic                               skip_req
);
   import rpt_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Decode

   rpt_state_s st_r;
   rpt_state_s st_nxt;
   logic       idle;
   logic       take;
   logic       is_conv;
   logic       is_ext;
   logic       is_table;
   logic       converter_mode_sel;
   logic       stack_wr;
   logic [SP_W-1:0] sp_inc;
   rpt_pc_t    stack_rd_data;

   assign idle     = (st_r.phase == RPT_IDLE);
   assign take     = idle && instr_valid;
   assign is_conv  = (instr == OP_CONV_READ);
   assign is_ext   = (instr == OP_EXT_SPLIT);
   assign is_table =
      (instr[INSTR_W-1:PREFIX_LSB] == OP_TABLE_PREFIX);
   assign converter_mode_sel =
      converter_ctrl_first[MODE_SEL_BIT];
   assign sp_inc   = st_r.sp + 3'h1;

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_nxt   = st_r;
      stack_wr = 1'b0;
      unique case (st_r.phase)
         RPT_IDLE: begin
            if (take && is_conv) begin
               if (converter_mode_sel) begin
                  st_nxt.regs.aux = cmp_reg[7:4];
                  st_nxt.regs.acc = cmp_reg[3:0];
               end else begin
                  st_nxt.regs.aux = ad_result[9:6];
                  st_nxt.regs.acc = ad_result[5:2];
               end
            end else if (take && is_ext) begin
               st_nxt.regs.aux = ext_reg[7:4];
               st_nxt.regs.acc = ext_reg[3:0];
            end else if (take && is_table) begin
               // Push happens at the new level, before any fetch
               st_nxt.sp       = sp_inc;
               stack_wr        = 1'b1;
               st_nxt.rom_addr = {instr[PAGE_W-1:0],
                                  st_r.regs.dptr,
                                  st_r.regs.acc};
               st_nxt.phase    = RPT_FETCH;
            end
         end
         RPT_FETCH: begin
            st_nxt.phase = RPT_RETURN;
         end
         RPT_RETURN: begin
            st_nxt.regs.aux  = rom_rdata[7:4];
            st_nxt.regs.acc  = rom_rdata[3:0];
            st_nxt.regs.dptr = {1'b0,
                                rom_rdata[ROM_DPTR_LSB+1:ROM_DPTR_LSB]};
            st_nxt.sp        = st_r.sp - 3'h1;
            st_nxt.phase     = RPT_IDLE;
         end
         default: begin
            st_nxt.phase = RPT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r.phase    <= RPT_IDLE;
         st_r.regs     <= '{dptr: DPTR_RST, aux: AUX_RST, acc: ACC_RST};
         st_r.sp       <= SP_RST;
         st_r.rom_addr <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Return stack; read of the pushed level lands in the return cycle

   rpt_stack_mem #(
      .WIDTH (PC_W),
      .DEPTH (STACK_DEPTH),
      .AW    (SP_W)
   ) u_stack (
      .clk       (clk),
      .rstn      (rstn),
      .wr_en     (stack_wr),
      .wr_addr   (sp_inc),
      .wr_data   (pc),
      .rd_addr   (st_r.sp),
      .rd_data_r (stack_rd_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign ready         = idle;
   assign hit           = take && (is_conv || is_ext || is_table);
   assign regs          = st_r.regs;
   assign stack_pointer = st_r.sp;
   assign rom_req       = (st_r.phase == RPT_FETCH);
   assign rom_addr      = st_r.rom_addr;
   assign pc_load       = (st_r.phase == RPT_RETURN);
   assign pc_load_val   = stack_rd_data;
   // None of these operations touch carry or skip
   assign carry_flag_we = 1'b0;
   assign skip_req      = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   logic start_tr;
   logic start_conv;
   logic start_ext;
   assign start_tr   = take && is_table;
   assign start_conv = take && is_conv;
   assign start_ext  = take && is_ext;

   a_conv_adc_mode: assert property (@(posedge clk) disable iff (!rstn)
      start_conv && !converter_ctrl_first[3] |=>
         regs.aux == $past(ad_result[9:6]) &&
         regs.acc == $past(ad_result[5:2]))
      else $error("converter mode load wrong");

   a_conv_cmp_mode: assert property (@(posedge clk) disable iff (!rstn)
      start_conv && converter_ctrl_first[3] |=>
         regs.aux == $past(cmp_reg[7:4]) &&
         regs.acc == $past(cmp_reg[3:0]))
      else $error("comparator mode load wrong");

   a_mode_sel_bit: assert property (@(posedge clk) disable iff (!rstn)
      start_conv && $stable(converter_ctrl_first[2:0]) &&
      converter_ctrl_first[3] |=> regs.acc == $past(cmp_reg[3:0]))
      else $error("mode selector not bit 3");

   a_ext_split: assert property (@(posedge clk) disable iff (!rstn)
      start_ext |=> ready && regs.aux == $past(ext_reg[7:4]) &&
         regs.acc == $past(ext_reg[3:0]) && $stable(regs.dptr))
      else $error("extension split wrong");

   a_table_three_cyc: assert property (@(posedge clk) disable iff (!rstn)
      start_tr |=> !ready [*2] ##1 ready)
      else $error("table read not three cycles");

   a_table_push: assert property (@(posedge clk) disable iff (!rstn)
      start_tr |=> stack_pointer == $past(stack_pointer) + 3'h1)
      else $error("stack not incremented");

   a_table_addr: assert property (@(posedge clk) disable iff (!rstn)
      start_tr |=> rom_req &&
         rom_addr == {$past(instr[4:0]), $past(regs.dptr),
                      $past(regs.acc)})
      else $error("table address wrong");

   a_table_nibbles: assert property (@(posedge clk) disable iff (!rstn)
      pc_load |=> regs.aux == $past(rom_rdata[7:4]) &&
         regs.acc == $past(rom_rdata[3:0]))
      else $error("fetched nibbles wrong");

   a_table_dptr: assert property (@(posedge clk) disable iff (!rstn)
      pc_load |=> regs.dptr[1:0] == $past(rom_rdata[9:8]))
      else $error("data pointer low bits wrong");

   a_table_dptr_top: assert property (@(posedge clk) disable iff (!rstn)
      pc_load |=> regs.dptr[2] == 1'b0)
      else $error("data pointer top not zero");

   a_table_return: assert property (@(posedge clk) disable iff (!rstn)
      start_tr ##2 1'b1 |-> pc_load && pc_load_val == $past(pc, 2)
         ##1 stack_pointer == $past(stack_pointer, 3))
      else $error("return address or pointer wrong");

   a_no_carry_skip: assert property (@(posedge clk) disable iff (!rstn)
      hit |-> !carry_flag_we && !skip_req [*3])
      else $error("carry or skip disturbed");

   c_conv_adc:   cover property (@(posedge clk) disable iff (!rstn)
      start_conv && !converter_ctrl_first[3]);
   c_conv_cmp:   cover property (@(posedge clk) disable iff (!rstn)
      start_conv && converter_ctrl_first[3]);
   c_ext_split:  cover property (@(posedge clk) disable iff (!rstn)
      start_ext);
   c_table_done: cover property (@(posedge clk) disable iff (!rstn)
      start_tr ##2 pc_load ##1 start_tr);

endmodule

/* core/rpt_pkg.sv */
/*
 * Shared constants and carriers for the register pair transfer slice:
 * opcode encodings, field positions, reset values and the packed structs
 * that carry the working registers and the table-read state.
 * Assumes a 10-bit instruction word and a 12-bit program counter.
 */
package rpt_pkg;

   localparam int unsigned INSTR_W     = 10;
   localparam int unsigned NIB_W       = 4;
   localparam int unsigned DPTR_W      = 3;
   localparam int unsigned PAGE_W      = 5;
   localparam int unsigned PCL_W       = DPTR_W + NIB_W;
   localparam int unsigned PC_W        = PAGE_W + PCL_W;
   localparam int unsigned SP_W        = 3;
   localparam int unsigned STACK_DEPTH = 8;
   localparam int unsigned AD_W        = 10;
   localparam int unsigned BYTE_W      = 8;

   typedef logic [INSTR_W-1:0] rpt_word_t;
   typedef logic [PC_W-1:0]    rpt_pc_t;
   typedef logic [NIB_W-1:0]   rpt_nib_t;

   // Opcodes
   localparam rpt_word_t OP_CONV_READ = 10'h279;
   localparam rpt_word_t OP_EXT_SPLIT = 10'h02a;
   localparam logic [PAGE_W-1:0] OP_TABLE_PREFIX = 5'h04;

   // Field positions
   localparam int unsigned PREFIX_LSB    = 5;
   localparam int unsigned MODE_SEL_BIT  = 3;
   localparam int unsigned ROM_DPTR_LSB  = 8;

   // Reset values
   localparam rpt_nib_t         ACC_RST  = 4'h0;
   localparam rpt_nib_t         AUX_RST  = 4'h0;
   localparam logic [DPTR_W-1:0] DPTR_RST = 3'h0;
   localparam logic [SP_W-1:0]   SP_RST   = 3'h7;

   // Machine cycles of the table read
   localparam int unsigned TABLE_CYCLES = 3;

   typedef enum logic [1:0] {
      RPT_IDLE,
      RPT_FETCH,
      RPT_RETURN
   } rpt_phase_e;

   typedef struct packed {
      logic [DPTR_W-1:0] dptr;
      rpt_nib_t          aux;
      rpt_nib_t          acc;
   } rpt_regs_s;

   typedef struct packed {
      rpt_phase_e        phase;
      rpt_regs_s         regs;
      logic [SP_W-1:0]   sp;
      rpt_pc_t           rom_addr;
   } rpt_state_s;

endpackage

/* core/rpt_stack_mem.sv */
/*
 * Return stack storage: one write port, one read port, registered read.
 * Assumes a single clock; read data appear one edge after the address.
 */
`timescale 1ns/10ps
module rpt_stack_mem #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = 8,
   parameter int unsigned AW    = 3
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data_r
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Storage itself is not reset; only the read register is
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data_r <= '0;
      end else begin
         rd_data_r <= mem[rd_addr];
      end
   end

endmodule

/* bench/rpt_core_tb.sv */
/*
 * Self-checking bench for the nibble transfer slice: random streams of
 * converter reads, extension splits, table reads, foreign opcodes and
 * idle cycles, compared with an integer model holding a return stack.
 * Assumes program memory data are wanted the cycle after rom_req.
 */
`timescale 1ns/10ps
module rpt_core_tb;
   import rpt_pkg::*;
   logic              clk, rstn, instr_valid, ready, hit, rom_req, pc_load;
   logic              carry_flag_we, skip_req;
   rpt_word_t         instr, rom_rdata;
   rpt_pc_t           pc, rom_addr, pc_load_val;
   logic [AD_W-1:0]   ad_result;
   logic [BYTE_W-1:0] cmp_reg, ext_reg;
   logic [NIB_W-1:0]  ctrl;
   rpt_regs_s         regs;
   logic [SP_W-1:0]   stack_pointer;
   integer            seed = 46;
   int                bad_count, cmp_count, m_acc, m_aux, m_dptr, m_sp;
   int                stk[$];

   rpt_core uut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid),
      .instr(instr), .pc(pc), .ad_result(ad_result), .cmp_reg(cmp_reg),
      .converter_ctrl_first(ctrl), .ext_reg(ext_reg),
      .rom_rdata(rom_rdata), .ready(ready), .hit(hit), .regs(regs),
      .stack_pointer(stack_pointer), .rom_req(rom_req),
      .rom_addr(rom_addr), .pc_load(pc_load), .pc_load_val(pc_load_val),
      .carry_flag_we(carry_flag_we), .skip_req(skip_req));

   initial clk = 1'b0;
   always #2 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [11:0] exp,
                      input logic [11:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask

   // Fresh values every cycle so stale data cannot pass for a match
   task automatic rand_in();
      ad_result = 10'($random(seed));
      cmp_reg   = 8'($random(seed));
      ext_reg   = 8'($random(seed));
      ctrl      = 4'($random(seed));
      pc        = 12'($random(seed));
      rom_rdata = 10'($random(seed));
   endtask

   task automatic chk_idle();
      chk("ready", 12'h1, 12'(ready));
      chk("acc", 12'(m_acc), 12'(regs.acc));
      chk("aux", 12'(m_aux), 12'(regs.aux));
      chk("dptr", 12'(m_dptr), 12'(regs.dptr));
      chk("sp", 12'(m_sp), 12'(stack_pointer));
      chk("rom_req", 12'h0, 12'(rom_req));
      chk("pc_load", 12'h0, 12'(pc_load));
      chk("no_carry_skip", 12'h0, 12'({carry_flag_we, skip_req}));
   endtask

   task automatic do_reset();
      rstn = 1'b0;
      // A stale request would be taken at the first edge after release
      instr_valid = 1'b0;
      m_acc = 0;
      m_aux = 0;
      m_dptr = 0;
      m_sp = 7;
      stk.delete();
      repeat (12) @(negedge clk);
      chk_idle();
      rstn = 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Kinds: 0/1 converter read in mode 0/1, 2 split, 3 table, 4 foreign
   // opcode, 5 valid low
   task automatic do_op(input int kind);
      logic [4:0] pg;
      int         a;
      @(negedge clk);
      rand_in();
      chk_idle();
      instr_valid = (kind != 5);
      pg = 5'($random(seed));
      case (kind)
         0, 1: begin
            ctrl[MODE_SEL_BIT] = (kind == 1);
            instr = OP_CONV_READ;
         end
         3: instr = {OP_TABLE_PREFIX, pg};
         4: begin
            instr = 10'($random(seed));
            while (instr == OP_CONV_READ || instr == OP_EXT_SPLIT ||
                   instr[9:5] == OP_TABLE_PREFIX) instr = instr + 10'h1;
         end
         default: instr = OP_EXT_SPLIT;
      endcase
      #1 chk("hit", 12'(kind < 4), 12'(hit));
      case (kind)
         0: begin
            m_aux = ad_result[9:6];
            m_acc = ad_result[5:2];
         end
         1: begin
            m_aux = cmp_reg[7:4];
            m_acc = cmp_reg[3:0];
         end
         2: begin
            m_aux = ext_reg[7:4];
            m_acc = ext_reg[3:0];
         end
         3: begin
            stk.push_back(int'(pc));
            m_sp = (m_sp + 1) % 8;
            a = int'({pg, 3'(m_dptr), 4'(m_acc)});
            // Requests during the busy cycles must be ignored
            @(negedge clk);
            rand_in();
            instr = OP_CONV_READ;
            #1 chk("busy1", 12'h0, 12'({ready, hit}));
            chk("rom_req", 12'h1, 12'(rom_req));
            chk("rom_addr", 12'(a), rom_addr);
            chk("sp_push", 12'(m_sp), 12'(stack_pointer));
            @(negedge clk);
            rand_in();
            instr = OP_EXT_SPLIT;
            #1 chk("busy2", 12'h0, 12'({ready, hit, rom_req}));
            chk("pc_load", 12'h1, 12'(pc_load));
            chk("pc_load_val", 12'(stk.pop_back()), pc_load_val);
            m_aux = rom_rdata[7:4];
            m_acc = rom_rdata[3:0];
            m_dptr = {1'b0, rom_rdata[9:8]};
            m_sp = (m_sp + 7) % 8;
         end
         default: ;
      endcase
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      instr = '0;
      rand_in();
      do_reset();
      for (int i = 0; i < 140; i++) begin
         // Mid-run reset must bring the stack pointer back too
         if (i == 70) do_reset();
         do_op({$random(seed)} % 6);
      end
      @(negedge clk);
      chk_idle();
      give_verdict();
   end

   // Run needs about 1 us; a hang is cut short well after that
   initial begin
      #40000;
      bad_count++;
      give_verdict();
   end
endmodule
